/* File: verilog/fp_map.svh */
`ifndef FP_MAP_SVH
`define FP_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FP_OFF_STATUS   12'h000
`define FP_OFF_MASK     12'h004
`define FP_OFF_SCAN     12'h008
`define FP_OFF_ROWS     12'h00C
`define FP_OFF_KEYDONE  12'h010
`define FP_OFF_MENU     12'h014
`define FP_OFF_SOFT     12'h018
`define FP_OFF_DADDR    12'h01C
`define FP_OFF_DDATA    12'h020
`define FP_OFF_LED      12'h024
`define FP_OFF_BEEP     12'h028
`define FP_OFF_TIME     12'h02C
`define FP_OFF_DATE     12'h030
`define FP_OFF_COMMIT   12'h034

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define FP_ST_KEY       0
`define FP_ST_BEEP      1
`define FP_ST_REFRESH   2
`define FP_LED_POWER    4
`define FP_LED_RST      9'h030
`define FP_MENU_ID      4'h0
`define FP_MENU_SETUP   4'h1
`define FP_SOFT_L_RST   4'h1
`define FP_SOFT_R_RST   4'h2
`define FP_DISP_CHARS   48
`define FP_DISP_BLANK   8'h20
`define FP_KEY_DECIMAL  4'hA
`define FP_KEY_COMMIT   4'hB
`define FP_KEY_LSOFT    4'hC
`define FP_KEY_RSOFT    4'hD
`define FP_KEY_FWD      4'hE
`define FP_KEY_BACK     4'hF
`define FP_BEEP_ONE     2'h1
`define FP_BEEP_TWO     2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FP_CLK_NS       20
`define FP_REFRESH_MS   1000
`define FP_BEEP_MS      100
`define FP_REFRESH_CYC  ((`FP_REFRESH_MS * 1000000) / `FP_CLK_NS)
`define FP_BEEP_CYC     ((`FP_BEEP_MS * 1000000) / `FP_CLK_NS)

`endif

/* File: verilog/fp_pkg.sv */
package fp_pkg;

	typedef enum logic [1:0] {
		BEEP_IDLE,
		BEEP_TONE,
		BEEP_GAP
	} beep_e;

	typedef struct packed {
		logic       time_load;
		logic       sec_clr;
		logic [3:0] hour;
		logic [5:0] minute;
		logic       pm;
		logic       date_load;
		logic [3:0] month;
		logic [4:0] day;
		logic [6:0] year;
	} rtc_s;

	typedef struct packed {
		logic       wr;
		logic [5:0] pos;
		logic [7:0] data;
	} lcd_s;

endpackage

/* File: verilog/front_panel_keypad_display.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fp_map.svh"

// Functional notes
// R1: Key activity interrupts; software then scans matrix
// R2: Sixteen keys: digits, decimal, commit, soft, nav
// R3: Display holds 48 characters on two lines
// R4: Display refreshed each second; LEDs/beeper on write
// R5: Display, LEDs, beeper reached as bus locations
// R6: Valid entry gives exactly one beep
// R7: Invalid entry gives two beeps, no change
// R8: Nine LEDs: four red faults, five green
// R9: Red LEDs: group, mod, demod, battery faults
// R10: Power LED lit whenever powered
// R11: One green mode LED per mode, exclusive
// R12: Identification menu shown after power-on
// R13: Soft keys jump to their labelled menus
// R14: Forward/back step menu items
// R15: Setup commit stores and advances item
// R16: Time entry hours, minutes, then AM/PM
// R17: Time commit clears seconds, loads clock
// R18: Date commit loads month, day, year
// R19: Interrupt held until cleared; held key silent
module front_panel_keypad_display import fp_pkg::*; #(
	parameter int REFRESH_CYC = `FP_REFRESH_CYC,
	parameter int BEEP_CYC    = `FP_BEEP_CYC
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	output logic             o_irq,
	input  wire logic [3:0]  i_key_row,
	output logic [3:0]       o_key_col,
	output lcd_s             o_lcd,
	output logic [8:0]       o_led,
	output logic             o_beeper,
	output rtc_s             o_rtc
);
	if (REFRESH_CYC < 2 || REFRESH_CYC >= (1 << 26))
		$error("REFRESH_CYC out of range");
	if (BEEP_CYC < 2 || BEEP_CYC >= (1 << 26))
		$error("BEEP_CYC out of range");

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic             pready;
		logic [31:0]      prdata;
		logic             pslverr;
		logic [2:0]       status;
		logic [2:0]       mask;
		logic             irq;
		logic             scan_act;
		logic [3:0]       scan_col;
		logic [3:0]       col;
		logic             col_all;
		logic [3:0]       rows;
		logic             armed;
		logic [3:0]       menu;
		logic [3:0]       item;
		logic [3:0]       soft_l;
		logic [3:0]       soft_r;
		logic [5:0]       dptr;
		logic [47:0][7:0] disp;
		logic [1:0]       mode;
		logic [8:0]       led;
		beep_e            beep_st;
		logic             beep_more;
		logic [25:0]      beep_cnt;
		logic             beeper;
		logic [3:0]       hour;
		logic [5:0]       minute;
		logic             pm;
		logic [3:0]       month;
		logic [4:0]       day;
		logic [6:0]       year;
		rtc_s             rtc;
		logic [25:0]      ref_cnt;
		logic             ref_busy;
		logic [5:0]       ref_idx;
		lcd_s             lcd;
	} state_s;
	state_s st;
	state_s next_st;
	logic   rst_meta;
	logic   rst_sync_n;
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction
	function automatic logic [3:0] mode_leds(input logic [1:0] m);
		mode_leds = 4'h1 << m;
	endfunction
	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end
	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic       wr;
		logic [2:0] set;
		logic [1:0] beep_req;
		logic       t_ok;
		logic       d_ok;
		logic [3:0] k;
		next_st  = st;
		wr       = i_psel && i_penable && st.pready && i_pwrite;
		set      = 3'b000;
		beep_req = 2'b00;
		k        = i_pwdata[3:0];
		t_ok     = (st.hour >= 4'd1) && (st.hour <= 4'd12) &&
		           (st.minute <= 6'd59);
		d_ok     = (st.month >= 4'd1) && (st.month <= 4'd12) &&
		           (st.day >= 5'd1) && (st.year <= 7'd99);
		// Bus read side, answered one cycle after setup
		next_st.pready  = i_psel && !i_penable;
		next_st.pslverr = 1'b0;
		next_st.prdata  = 32'h0000_0000;
		if (i_psel && !i_penable) begin
			case (i_paddr)
			`FP_OFF_STATUS: next_st.prdata[2:0] = st.status;
			`FP_OFF_MASK:   next_st.prdata[2:0] = st.mask;
			`FP_OFF_SCAN:   next_st.prdata[4:0] = {st.scan_act, st.scan_col};
			`FP_OFF_ROWS:   next_st.prdata[4:0] = {st.armed, st.rows};
			`FP_OFF_MENU:   next_st.prdata[7:0] = {st.item, st.menu};
			`FP_OFF_SOFT:   next_st.prdata[7:0] = {st.soft_r, st.soft_l};
			`FP_OFF_DADDR:  next_st.prdata[5:0] = st.dptr;
			`FP_OFF_LED:    next_st.prdata[5:0] = {st.mode, st.led[3:0]};
			`FP_OFF_TIME: begin
				next_st.prdata[3:0]  = st.hour;
				next_st.prdata[13:8] = st.minute;
				next_st.prdata[16]   = st.pm;
			end
			`FP_OFF_DATE: begin
				next_st.prdata[3:0]   = st.month;
				next_st.prdata[12:8]  = st.day;
				next_st.prdata[22:16] = st.year;
			end
			`FP_OFF_KEYDONE, `FP_OFF_DDATA, `FP_OFF_BEEP,
			`FP_OFF_COMMIT: next_st.prdata = 32'h0000_0000;
			default:        next_st.pslverr = 1'b1;
			endcase
		end
		// Keypad: all columns driven while idle, software columns in scan
		next_st.col     = st.scan_act ? st.scan_col : 4'hF;
		next_st.col_all = (st.col == 4'hF);
		next_st.rows    = i_key_row;
		if (st.col_all && !st.scan_act) begin
			if (|st.rows && st.armed) begin
				set[`FP_ST_KEY] = 1'b1; // R1
				next_st.armed   = 1'b0; // R19
			end else if (!(|st.rows)) begin
				next_st.armed = 1'b1; // R19
			end
		end
		// Register writes
		next_st.rtc.time_load = 1'b0;
		next_st.rtc.sec_clr   = 1'b0;
		next_st.rtc.date_load = 1'b0;
		if (wr) begin
			if (hit(i_paddr, `FP_OFF_MASK))
				next_st.mask = i_pwdata[2:0];
			if (hit(i_paddr, `FP_OFF_SCAN)) begin
				next_st.scan_col = i_pwdata[3:0]; // R1
				next_st.scan_act = i_pwdata[4];
			end
			if (hit(i_paddr, `FP_OFF_KEYDONE)) begin
				next_st.scan_act = 1'b0;
				beep_req = `FP_BEEP_ONE; // R6
				if (!i_pwdata[4]) begin
					beep_req = `FP_BEEP_TWO; // R7
				end else begin
					case (k) // R2
					`FP_KEY_LSOFT: begin
						next_st.menu = st.soft_l; // R13
						next_st.item = 4'h0;
					end
					`FP_KEY_RSOFT: begin
						next_st.menu = st.soft_r; // R13
						next_st.item = 4'h0;
					end
					`FP_KEY_FWD: begin
						if (st.item == 4'hF)
							beep_req = `FP_BEEP_TWO; // R7
						else
							next_st.item = st.item + 4'h1; // R14
					end
					`FP_KEY_BACK: begin
						if (st.item == 4'h0)
							beep_req = `FP_BEEP_TWO; // R7
						else
							next_st.item = st.item - 4'h1; // R14
					end
					`FP_KEY_COMMIT: begin
						if (st.menu == `FP_MENU_SETUP && st.item != 4'hF)
							next_st.item = st.item + 4'h1; // R15
					end
					default: beep_req = `FP_BEEP_ONE;
					endcase
				end
			end
			if (hit(i_paddr, `FP_OFF_MENU)) begin
				next_st.menu = i_pwdata[3:0];
				next_st.item = i_pwdata[7:4];
			end
			if (hit(i_paddr, `FP_OFF_SOFT)) begin
				next_st.soft_l = i_pwdata[3:0];
				next_st.soft_r = i_pwdata[7:4];
			end
			if (hit(i_paddr, `FP_OFF_DADDR))
				next_st.dptr = (i_pwdata[5:0] < 6'd48) ? i_pwdata[5:0] : 6'd0;
			if (hit(i_paddr, `FP_OFF_DDATA)) begin
				next_st.disp[st.dptr] = i_pwdata[7:0]; // R5
				next_st.dptr = (st.dptr == 6'd47) ? 6'd0 : st.dptr + 6'd1; // R3
			end
			if (hit(i_paddr, `FP_OFF_LED)) begin
				next_st.mode     = i_pwdata[5:4];
				next_st.led[3:0] = i_pwdata[3:0]; // R9
				next_st.led[8:5] = mode_leds(i_pwdata[5:4]); // R11
			end
			if (hit(i_paddr, `FP_OFF_BEEP))
				beep_req = i_pwdata[1:0]; // R5
			if (hit(i_paddr, `FP_OFF_TIME)) begin
				next_st.hour   = i_pwdata[3:0];
				next_st.minute = i_pwdata[13:8];
				next_st.pm     = i_pwdata[16]; // R16
			end
			if (hit(i_paddr, `FP_OFF_DATE)) begin
				next_st.month = i_pwdata[3:0];
				next_st.day   = i_pwdata[12:8];
				next_st.year  = i_pwdata[22:16];
			end
			if (hit(i_paddr, `FP_OFF_COMMIT)) begin
				beep_req = `FP_BEEP_ONE;
				if ((i_pwdata[0] && !t_ok) || (i_pwdata[1] && !d_ok)) begin
					beep_req = `FP_BEEP_TWO; // R7
				end else begin
					if (i_pwdata[0]) begin
						next_st.rtc.time_load = 1'b1; // R17
						next_st.rtc.sec_clr   = 1'b1; // R17
						next_st.rtc.hour      = st.hour;
						next_st.rtc.minute    = st.minute;
						next_st.rtc.pm        = st.pm;
					end
					if (i_pwdata[1]) begin
						next_st.rtc.date_load = 1'b1; // R18
						next_st.rtc.month     = st.month;
						next_st.rtc.day       = st.day;
						next_st.rtc.year      = st.year;
					end
				end
			end
		end
		next_st.led[`FP_LED_POWER] = 1'b1; // R10
		// Beeper: one or two tones separated by a silent gap
		case (st.beep_st)
		BEEP_IDLE: next_st.beep_cnt = 26'd0;
		BEEP_TONE: begin
			next_st.beep_cnt = st.beep_cnt + 26'd1;
			if (st.beep_cnt == 26'(BEEP_CYC - 1)) begin
				next_st.beep_cnt = 26'd0;
				if (st.beep_more) begin
					next_st.beep_st = BEEP_GAP;
				end else begin
					next_st.beep_st     = BEEP_IDLE;
					set[`FP_ST_BEEP]    = 1'b1;
				end
			end
		end
		BEEP_GAP: begin
			next_st.beep_cnt = st.beep_cnt + 26'd1;
			if (st.beep_cnt == 26'(BEEP_CYC - 1)) begin
				next_st.beep_cnt  = 26'd0;
				next_st.beep_more = 1'b0;
				next_st.beep_st   = BEEP_TONE;
			end
		end
		default: next_st.beep_st = BEEP_IDLE;
		endcase
		if (beep_req == `FP_BEEP_ONE || beep_req == `FP_BEEP_TWO) begin
			next_st.beep_st   = BEEP_TONE; // R6
			next_st.beep_cnt  = 26'd0;
			next_st.beep_more = (beep_req == `FP_BEEP_TWO); // R7
		end
		next_st.beeper = (next_st.beep_st == BEEP_TONE);
		// Once-per-second display refresh, one character per cycle
		next_st.lcd.wr = 1'b0;
		next_st.ref_cnt = st.ref_cnt + 26'd1;
		if (st.ref_cnt == 26'(REFRESH_CYC - 1)) begin
			next_st.ref_cnt  = 26'd0;
			next_st.ref_busy = 1'b1; // R4
			next_st.ref_idx  = 6'd0;
		end
		if (st.ref_busy) begin
			next_st.lcd.wr   = 1'b1;
			next_st.lcd.pos  = st.ref_idx;
			next_st.lcd.data = st.disp[st.ref_idx]; // R3
			next_st.ref_idx  = st.ref_idx + 6'd1;
			if (st.ref_idx == 6'(`FP_DISP_CHARS - 1)) begin
				next_st.ref_busy    = 1'b0;
				set[`FP_ST_REFRESH] = 1'b1;
			end
		end
		// Sticky status: a new event wins over a same-cycle clear
		if (wr && hit(i_paddr, `FP_OFF_STATUS))
			next_st.status = (st.status & ~i_pwdata[2:0]) | set; // R19
		else
			next_st.status = st.status | set;
		next_st.irq = |(next_st.status & next_st.mask); // R1
	end
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st          <= '0;
			st.col      <= 4'hF;
			st.armed    <= 1'b1;
			st.menu     <= `FP_MENU_ID; // R12
			st.soft_l   <= `FP_SOFT_L_RST;
			st.soft_r   <= `FP_SOFT_R_RST;
			st.disp     <= {`FP_DISP_CHARS{`FP_DISP_BLANK}};
			st.led      <= `FP_LED_RST; // R10
			st.beep_st  <= BEEP_IDLE;
			st.hour     <= 4'h1;
			st.month    <= 4'h1;
			st.day      <= 5'h01;
		end else begin
			st <= next_st;
		end
	end
	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_pready  = st.pready;
	assign o_prdata  = st.prdata;
	assign o_pslverr = st.pslverr;
	assign o_irq     = st.irq;
	assign o_key_col = st.col;
	assign o_lcd     = st.lcd;
	assign o_led     = st.led; // R8
	assign o_beeper  = st.beeper;
	assign o_rtc     = st.rtc;
endmodule
`default_nettype wire

/* File: bench/keypad_matrix_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------
// Keypad matrix
// ----------
module keypad_matrix_model (
	input  wire logic [3:0] i_key_col,
	input  wire logic [4:0] i_key,
	output logic      [3:0] o_key_row
);
	// Code bits [3:2] pick the row, [1:0] the column; open rows pull low
	assign o_key_row = (i_key[4] && i_key_col[i_key[1:0]]) ?
		4'h1 << i_key[3:2] : 4'h0;
endmodule
`default_nettype wire

/* File: bench/fp_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fp_map.svh"
module fp_props import fp_pkg::*; #(
	parameter int REFRESH_CYC = 200,
	parameter int BEEP_CYC    = 10
) (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire lcd_s        o_lcd,
	input wire logic [8:0]  o_led,
	input wire logic        o_beeper,
	input wire rtc_s        o_rtc
);
	// ----------
	// Helpers
	// ----------
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic acc;
	int   tone;
	assign acc = i_psel && i_penable && i_pwrite && i_paddr == `FP_OFF_COMMIT;
	// Length of the current tone
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			tone <= 0;
		else
			tone <= o_beeper ? tone + 1 : 0;
	end
	// ----------
	// Properties
	// ----------
	a_ready_after_setup: assert property (
		i_psel && !i_penable |=> o_pready) else $error("pready late");
	a_ready_one_cycle: assert property (
		o_pready |=> !o_pready) else $error("pready stuck");
	a_error_with_ready: assert property (
		o_pslverr |-> o_pready) else $error("pslverr alone");
	a_power_lit: assert property (
		o_led[4]) else $error("power led off");
	a_mode_one_hot: assert property (
		$onehot(o_led[8:5])) else $error("mode leds not one hot");
	a_lcd_in_range: assert property (
		o_lcd.wr |-> o_lcd.pos < 6'd48) else $error("lcd pos range");
	a_lcd_step: assert property (
		o_lcd.wr && o_lcd.pos != 6'd0 |-> $past(o_lcd.wr) &&
		o_lcd.pos == $past(o_lcd.pos) + 6'd1) else $error("lcd order");
	a_rtc_load_cause: assert property (
		o_rtc.time_load || o_rtc.date_load |-> $past(acc) || $past(acc, 2))
		else $error("rtc load without commit");
	a_seconds_clear: assert property (
		o_rtc.time_load |-> o_rtc.sec_clr) else $error("seconds kept");
	a_tone_length: assert property (
		$fell(o_beeper) |-> tone == BEEP_CYC) else $error("tone length");
	c_error: cover property (o_pslverr);
	c_tone: cover property ($fell(o_beeper));
	c_date: cover property (o_rtc.date_load);
endmodule
bind front_panel_keypad_display fp_props #(
	.REFRESH_CYC(REFRESH_CYC),
	.BEEP_CYC   (BEEP_CYC)
) i_fp_props (
	.i_clk_sys(i_clk_sys),
	.i_rst_n  (i_rst_n),
	.i_psel   (i_psel),
	.i_penable(i_penable),
	.i_pwrite (i_pwrite),
	.i_paddr  (i_paddr),
	.o_pready (o_pready),
	.o_pslverr(o_pslverr),
	.o_lcd    (o_lcd),
	.o_led    (o_led),
	.o_beeper (o_beeper),
	.o_rtc    (o_rtc)
);
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fp_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module testbench import fp_pkg::*;;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic        pready, pslverr, serr, irq, beeper;
	logic [3:0]  row, col;
	logic [4:0]  key = '0;
	logic [8:0]  led;
	lcd_s        lcd;
	rtc_s        rtc;
	int          err_total = 0, n_compared = 0, cyc = 0, n_tl = 0, n_dl = 0;
	int          i, n;
	logic [3:0]  keys [4] = '{4'h0, 4'h6, 4'h9, 4'hC};
	logic [3:0]  kc [6] = '{4'hB, 4'hE, 4'hF, 4'hF, 4'hF, 4'hD};
	logic [7:0]  km [6] = '{8'h11, 8'h21, 8'h11, 8'h01, 8'h01, 8'h02};
	int          kb [6] = '{1, 1, 1, 1, 2, 1};
	front_panel_keypad_display #(.REFRESH_CYC(200), .BEEP_CYC(10))
	i_front_panel_keypad_display (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .o_irq(irq),
		.i_key_row(row), .o_key_col(col), .o_lcd(lcd), .o_led(led),
		.o_beeper(beeper), .o_rtc(rtc));
	keypad_matrix_model i_keypad_matrix_model (.i_key_col(col),
		.i_key(key), .o_key_row(row));
	// ----------
	// Clock, timeout, load monitor
	// ----------
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (rtc.time_load === 1'b1)
			n_tl++;
		if (rtc.date_load === 1'b1)
			n_dl++;
		if (cyc == 6000) begin
			$display("Error timeout");
			err_total++;
			test_done();
		end
	end
	// ----------
	// Tasks
	// ----------
	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic beeps(input int e);
		int   c;
		logic p;
		c = 0;
		p = 1'b0;
		repeat (40) begin
			@(posedge clk);
			if (beeper === 1'b1 && p === 1'b0)
				c++;
			p = beeper;
		end
		`CHK("beeps", e, c)
	endtask
	task automatic press(input logic [3:0] k);
		key <= {1'b1, k};
		n = 0;
		while (irq !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		`CHK("irq", 1'b1, irq)
		wr(`FP_OFF_SCAN, {27'h0, 1'b1, 4'h1 << k[1:0]});
		@(posedge clk);
		rd(`FP_OFF_ROWS);
		`CHK("rows", 4'h1 << k[3:2], q[3:0])
		wr(`FP_OFF_SCAN, {27'h0, 1'b1, ~(4'h1 << k[1:0])});
		@(posedge clk);
		rd(`FP_OFF_ROWS);
		`CHK("rows other", 4'h0, q[3:0])
		wr(`FP_OFF_SCAN, 32'h0);
		wr(`FP_OFF_KEYDONE, {27'h0, 1'b1, k});
		beeps(1);
		`CHK("irq held", 1'b1, irq)
		wr(`FP_OFF_STATUS, 32'h1);
		repeat (3) @(posedge clk);
		`CHK("irq held key", 1'b0, irq)
		key <= 5'h0;
		repeat (3) @(posedge clk);
	endtask
	// ----------
	// Sequence
	// ----------
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("led rst", 9'h030, led)
		rd(`FP_OFF_MENU);
		`CHK("menu rst", 8'h00, q[7:0])
		rd(`FP_OFF_SOFT);
		`CHK("soft rst", 8'h21, q[7:0])
		rd(12'h038);
		`CHK("unmapped", 1'b1, serr)
		for (i = 0; i < 4; i++) begin
			wr(`FP_OFF_LED, {26'h0, 2'(i), 4'h1 << i});
			`CHK("led", {4'h1 << i, 1'b1, 4'h1 << i}, led)
		end
		wr(`FP_OFF_MASK, 32'h1);
		for (i = 0; i < 4; i++)
			press(keys[i]);
		wr(`FP_OFF_MASK, 32'h0);
		key <= 5'h15;
		repeat (8) @(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		rd(`FP_OFF_STATUS);
		`CHK("status key", 1'b1, q[0])
		key <= 5'h0;
		wr(`FP_OFF_STATUS, 32'h1);
		for (i = 0; i < 6; i++) begin
			wr(`FP_OFF_KEYDONE, {27'h0, 1'b1, kc[i]});
			beeps(kb[i]);
			rd(`FP_OFF_MENU);
			`CHK("menu", km[i], q[7:0])
		end
		wr(`FP_OFF_KEYDONE, 32'h5);
		beeps(2);
		wr(`FP_OFF_BEEP, 32'h2);
		beeps(2);
		wr(`FP_OFF_TIME, 32'h0001_1E07);
		wr(`FP_OFF_COMMIT, 32'h1);
		beeps(1);
		wr(`FP_OFF_TIME, 32'h0001_1E0D);
		wr(`FP_OFF_COMMIT, 32'h1);
		beeps(2);
		`CHK("time loads", 1, n_tl)
		`CHK("time", {4'h7, 6'h1E, 1'b1}, {rtc.hour, rtc.minute, rtc.pm})
		wr(`FP_OFF_DATE, 32'h0063_1F0C);
		wr(`FP_OFF_COMMIT, 32'h2);
		beeps(1);
		`CHK("date loads", 1, n_dl)
		`CHK("date", {4'hC, 5'h1F, 7'h63}, {rtc.month, rtc.day, rtc.year})
		wr(`FP_OFF_STATUS, 32'h4);
		wr(`FP_OFF_DADDR, 32'h2F);
		wr(`FP_OFF_DDATA, 32'h41);
		wr(`FP_OFF_DDATA, 32'h42);
		n = 0;
		repeat (200) begin
			@(posedge clk);
			if (lcd.wr === 1'b1) begin
				n++;
				if (lcd.pos == 6'd47)
					`CHK("lcd 47", 8'h41, lcd.data)
				if (lcd.pos == 6'd0)
					`CHK("lcd 0", 8'h42, lcd.data)
			end
		end
		`CHK("lcd writes", 48, n)
		rd(`FP_OFF_STATUS);
		`CHK("refresh", 1'b1, q[2])
		test_done();
	end
endmodule
`default_nettype wire
